// ==== include/sgc_pkg.sv ====
// Shared constants and types for the configuration bus target and pin block.
// Assumes one system clock; all pin and analog status inputs are asynchronous.
package sgc_pkg;
	////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] SGC_REG_SOFT_RST = 8'h00;
	localparam logic [7:0] SGC_REG_DEV_ADDR = 8'h01;
	localparam logic [7:0] SGC_REG_PIN0 = 8'h02;
	localparam logic [7:0] SGC_REG_PIN1 = 8'h03;
	localparam logic [7:0] SGC_REG_PIN2 = 8'h04;
	localparam logic [7:0] SGC_REG_PIN_LVL = 8'h05;
	localparam int SGC_SOFT_RST_BIT = 0;
	localparam logic [6:0] SGC_DEV_ADDR_RST = 7'h2d;
	localparam logic [7:0] SGC_PIN_CTRL_RST = 8'h00;
	localparam logic [2:0] SGC_HOST_OUT_RST = 3'h0;
	////////////////////////////////////////////////////////////////////////////
	localparam logic [3:0] SGC_FN_HOST_OUT = 4'h0;
	localparam logic [3:0] SGC_FN_HOST_IN = 4'h1;
	localparam logic [3:0] SGC_FN_STAT = 4'h2;
	localparam logic [3:0] SGC_FN_ALT1 = 4'h3;
	localparam logic [3:0] SGC_FN_ALT2 = 4'h4;
	localparam logic [1:0] SGC_BIAS_NONE = 2'h0;
	localparam logic [1:0] SGC_BIAS_DOWN = 2'h1;
	localparam logic [1:0] SGC_BIAS_UP = 2'h2;
	localparam logic [4:0] SGC_DIV20_LAST = 5'h09;
	localparam logic [7:0] SGC_CCLK_LAST = 8'h3f;
	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [3:0] func;
		logic [1:0] bias;
		logic in_en;
		logic out_en;
	} sgc_pin_ctrl_s;

	typedef struct packed {
		logic out;
		logic oe;
		logic pu;
		logic pd;
		logic ibe;
	} sgc_pad_s;

	typedef enum logic [2:0] {
		SGC_ST_IDLE = 3'b000,
		SGC_ST_RX = 3'b001,
		SGC_ST_RXACK = 3'b010,
		SGC_ST_TX = 3'b011,
		SGC_ST_TXACK = 3'b100
	} sgc_state_e;

	typedef enum logic [1:0] {
		SGC_KIND_ADDR = 2'b00,
		SGC_KIND_IDX = 2'b01,
		SGC_KIND_DATA = 2'b10
	} sgc_kind_e;
endpackage : sgc_pkg

// ==== logic/sgc_gpio_pin.sv ====
// One general-purpose pin: registered pad controls and gated input level.
// Assumes the pad level arrives already synchronised.
`timescale 1ns/1ps
module sgc_gpio_pin (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input sgc_pkg::sgc_pin_ctrl_s i_ctrl,
	input wire logic i_src_ok,
	input wire logic i_src_lvl,
	input wire logic i_pin_lvl,
	output sgc_pkg::sgc_pad_s o_pad,
	output logic o_in_lvl
);
	import sgc_pkg::*;

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			o_pad <= '0;
			o_in_lvl <= 1'b0;
		end else begin
			o_pad.out <= i_src_lvl;
			o_pad.oe <= i_ctrl.out_en & i_src_ok; // [RULE18] [RULE23]
			o_pad.pu <= (i_ctrl.bias == SGC_BIAS_UP); // [RULE16]
			o_pad.pd <= (i_ctrl.bias == SGC_BIAS_DOWN); // [RULE16]
			o_pad.ibe <= i_ctrl.in_en; // [RULE17]
			o_in_lvl <= i_ctrl.in_en & i_pin_lvl; // [RULE17]
		end
	end
endmodule : sgc_gpio_pin

// ==== logic/sgc_smbus_gpio.sv ====
// Configuration bus target with register file and three general-purpose pins.
// Assumes open-drain bus pins resolved outside; status inputs are asynchronous,
// clock ticks are one-cycle pulses already on i_sys_clk.
//
// Functional notes
// RULE1 - Plain bus target: address match, index, data; no address resolution.
// RULE2 - Bus is ignored and data released while the select input is low.
// RULE3 - Data line changes only while the clock line is low.
// RULE4 - Start and stop are detected as data edges during clock high.
// RULE5 - Eight bits MSB first, then one acknowledge bit from the receiver.
// RULE6 - Acknowledge drives data low; not-acknowledge leaves it released.
// RULE7 - Host writes address with direction low, index, then data.
// RULE8 - Index increments after each stored byte for following bytes.
// RULE9 - Host ends a write with a stop after the last acknowledge.
// RULE10 - Read: index write, repeated start, address with direction high.
// RULE11 - Host not-acknowledge on a read byte makes the target stop driving.
// RULE12 - Each pin has a control register; upper nibble picks the function.
// RULE13 - Pin 0: host output, host input, input-0 signal present.
// RULE14 - Pin 1: reset status, output, input, input-1 present, loop lock.
// RULE15 - Pin 2: output, input, constant clock, transmit and recovered clock /20.
// RULE16 - Bits 3:2 pick bias: none, pulldown, pullup, reserved.
// RULE17 - Bit 1 enables the input buffer; cleared for output use.
// RULE18 - Bit 0 enables the driver; zero means high impedance.
// RULE19 - Value 21h in pin 0 control drives input-0 presence out.
// RULE20 - Several targets on one bus should each get a select line.
// RULE21 - Soft reset restores defaults but keeps the changed device address.
// RULE22 - Power-on or reset pin low restores every register default.
// RULE23 - Undefined function codes leave the pin in high impedance.
`timescale 1ns/1ps
module sgc_smbus_gpio (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_reset_n,
	input wire logic i_config_bus_select,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic i_sig_det0,
	input wire logic i_sig_det1,
	input wire logic i_cdr_lock,
	input wire logic i_txclk_tick,
	input wire logic i_cdrclk_tick,
	input wire logic [2:0] i_pin,
	output sgc_pkg::sgc_pad_s o_pad0,
	output sgc_pkg::sgc_pad_s o_pad1,
	output sgc_pkg::sgc_pad_s o_pad2
);
	import sgc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Returns {source valid, source level}; host input and unknown codes do not drive.
	function automatic logic [1:0] pin_sel(input logic [1:0] n, input logic [3:0] fn,
			input logic host, input logic [7:0] st);
		logic [1:0] r;
		r = 2'b00;
		if (fn == SGC_FN_HOST_OUT) begin
			r = {1'b1, host};
		end else if (fn == SGC_FN_STAT) begin
			r = {1'b1, st[n]}; // [RULE13] [RULE14] [RULE15]
		end else if (fn == SGC_FN_ALT1 && n != 2'd0) begin
			r = {1'b1, st[{1'b0, n} + 3'd2]}; // [RULE14] [RULE15]
		end else if (fn == SGC_FN_ALT2 && n != 2'd0) begin
			r = {1'b1, st[{1'b0, n} + 3'd4]}; // [RULE14] [RULE15]
		end
		return r; // [RULE23]
	endfunction : pin_sel

	function automatic logic [4:0] div_step(input logic [4:0] c);
		return (c == SGC_DIV20_LAST) ? 5'h00 : c + 5'h01;
	endfunction : div_step

	////////////////////////////////////////////////////////////////////////////
	logic [3:0] bus_f;
	logic [5:0] stat_f;
	logic cs_f;
	logic scl_f;
	logic sda_f;
	logic rst_all;
	logic scl_p_q;
	logic sda_p_q;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;

	sgc_sync #(.W(4), .RSTV(4'hf)) u_bus_sync (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_async({i_reset_n, i_sda, i_scl, i_config_bus_select}),
		.o_level(bus_f)
	);

	sgc_sync #(.W(6), .RSTV(6'h00)) u_stat_sync (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_async({i_pin, i_cdr_lock, i_sig_det1, i_sig_det0}),
		.o_level(stat_f)
	);

	assign cs_f = bus_f[0];
	assign scl_f = bus_f[1];
	assign sda_f = bus_f[2];
	assign rst_all = i_sys_rst | ~bus_f[3]; // [RULE22]

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_f;
			sda_p_q <= sda_f;
		end
	end

	assign scl_rise = scl_f & ~scl_p_q;
	assign scl_fall = ~scl_f & scl_p_q;
	assign start = cs_f & scl_f & scl_p_q & sda_p_q & ~sda_f; // [RULE4]
	assign stop = cs_f & scl_f & scl_p_q & ~sda_p_q & sda_f; // [RULE4]

	////////////////////////////////////////////////////////////////////////////
	sgc_state_e st_q;
	sgc_kind_e kind_q;
	logic [2:0] bit_q;
	logic [7:0] sh_q;
	logic [7:0] idx_q;
	logic rd_q;
	logic ack_q;
	logic ack_on_q;
	logic drive_q;
	logic [7:0] rx_byte;
	logic byte_done;
	logic wr_en;
	logic [7:0] rd_data;
	logic [6:0] dev_addr_q;
	logic [7:0] ctrl_q [0:2];
	logic [2:0] host_out_q;
	logic [2:0] in_lvl;
	logic por_q;

	assign rx_byte = {sh_q[6:0], sda_f};
	assign byte_done = (st_q == SGC_ST_RX) && scl_rise && (bit_q == 3'd7);
	assign wr_en = byte_done && (kind_q == SGC_KIND_DATA); // [RULE7]

	always_comb begin
		case (idx_q)
			SGC_REG_DEV_ADDR: rd_data = {1'b0, dev_addr_q};
			SGC_REG_PIN0: rd_data = ctrl_q[0];
			SGC_REG_PIN1: rd_data = ctrl_q[1];
			SGC_REG_PIN2: rd_data = ctrl_q[2];
			SGC_REG_PIN_LVL: rd_data = {1'b0, in_lvl, 1'b0, host_out_q};
			default: rd_data = 8'h00;
		endcase
	end

	// The bus engine stops at any point the select drops, so a half transfer never
	// leaves the data line held low by this target.
	always_ff @(posedge i_sys_clk) begin
		if (rst_all || !cs_f) begin // [RULE2]
			st_q <= SGC_ST_IDLE;
			drive_q <= 1'b0;
			kind_q <= SGC_KIND_ADDR;
			bit_q <= 3'd0;
			ack_on_q <= 1'b0;
		end else if (start) begin // [RULE4] [RULE10]
			st_q <= SGC_ST_RX;
			kind_q <= SGC_KIND_ADDR;
			bit_q <= 3'd0;
			drive_q <= 1'b0;
			ack_on_q <= 1'b0;
		end else if (stop) begin // [RULE9]
			st_q <= SGC_ST_IDLE;
			drive_q <= 1'b0;
		end else begin
			case (st_q)
				SGC_ST_RX: begin
					if (scl_rise) begin
						bit_q <= bit_q + 3'd1;
						if (bit_q == 3'd7) begin // [RULE5]
							st_q <= SGC_ST_RXACK;
							ack_on_q <= 1'b0;
						end
					end
				end
				SGC_ST_RXACK: begin
					if (scl_fall && !ack_on_q) begin
						drive_q <= ack_q; // [RULE6] [RULE3]
						ack_on_q <= 1'b1;
					end else if (scl_fall) begin
						ack_on_q <= 1'b0;
						bit_q <= 3'd0;
						if (!ack_q) begin
							st_q <= SGC_ST_IDLE;
							drive_q <= 1'b0;
						end else if (kind_q == SGC_KIND_ADDR && rd_q) begin // [RULE10]
							st_q <= SGC_ST_TX;
							drive_q <= ~rd_data[7];
						end else begin
							st_q <= SGC_ST_RX;
							drive_q <= 1'b0;
							kind_q <= (kind_q == SGC_KIND_ADDR) ? SGC_KIND_IDX : SGC_KIND_DATA;
						end
					end
				end
				SGC_ST_TX: begin
					if (scl_fall) begin
						if (bit_q == 3'd7) begin
							st_q <= SGC_ST_TXACK;
							drive_q <= 1'b0;
							ack_on_q <= 1'b0;
						end else begin
							bit_q <= bit_q + 3'd1;
							drive_q <= ~sh_q[6]; // [RULE5] [RULE3]
						end
					end
				end
				SGC_ST_TXACK: begin
					if (scl_rise && sda_f) begin
						st_q <= SGC_ST_IDLE; // [RULE11]
					end else if (scl_rise) begin
						ack_on_q <= 1'b1;
					end else if (scl_fall && ack_on_q) begin
						st_q <= SGC_ST_TX;
						bit_q <= 3'd0;
						drive_q <= ~rd_data[7];
					end
				end
				default: begin
					st_q <= SGC_ST_IDLE;
					drive_q <= 1'b0;
				end
			endcase
		end
	end

	// Shift register, acknowledge decision and register index.
	always_ff @(posedge i_sys_clk) begin
		if (rst_all) begin
			sh_q <= 8'h00;
			idx_q <= 8'h00;
			rd_q <= 1'b0;
			ack_q <= 1'b0;
		end else begin
			if (st_q == SGC_ST_RX && scl_rise) begin
				sh_q <= rx_byte;
			end
			if (st_q == SGC_ST_RXACK && scl_fall && ack_on_q) begin
				sh_q <= rd_data;
			end else if (st_q == SGC_ST_TXACK && scl_fall && ack_on_q) begin
				sh_q <= rd_data;
			end else if (st_q == SGC_ST_TX && scl_fall) begin
				sh_q <= {sh_q[6:0], 1'b0};
			end
			if (byte_done) begin
				case (kind_q)
					SGC_KIND_ADDR: begin
						ack_q <= (rx_byte[7:1] == dev_addr_q); // [RULE1]
						rd_q <= rx_byte[0];
					end
					SGC_KIND_IDX: begin
						ack_q <= 1'b1;
						idx_q <= rx_byte;
					end
					default: begin
						ack_q <= 1'b1;
						idx_q <= idx_q + 8'h01; // [RULE8]
					end
				endcase
			end
			if (st_q == SGC_ST_TXACK && scl_rise && !sda_f) begin
				idx_q <= idx_q + 8'h01;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			o_sda_oe <= 1'b0;
			o_sda_out <= 1'b0;
		end else begin
			o_sda_oe <= drive_q;
			o_sda_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_sys_clk) begin
		if (rst_all) begin // [RULE22]
			dev_addr_q <= SGC_DEV_ADDR_RST;
			ctrl_q <= '{SGC_PIN_CTRL_RST, SGC_PIN_CTRL_RST, SGC_PIN_CTRL_RST};
			host_out_q <= SGC_HOST_OUT_RST;
		end else if (wr_en) begin
			case (idx_q)
				SGC_REG_SOFT_RST: begin
					if (rx_byte[SGC_SOFT_RST_BIT]) begin // [RULE21]
						ctrl_q <= '{SGC_PIN_CTRL_RST, SGC_PIN_CTRL_RST, SGC_PIN_CTRL_RST};
						host_out_q <= SGC_HOST_OUT_RST;
					end
				end
				SGC_REG_DEV_ADDR: dev_addr_q <= rx_byte[6:0];
				SGC_REG_PIN0: ctrl_q[0] <= rx_byte; // [RULE12]
				SGC_REG_PIN1: ctrl_q[1] <= rx_byte;
				SGC_REG_PIN2: ctrl_q[2] <= rx_byte;
				SGC_REG_PIN_LVL: host_out_q <= rx_byte[2:0];
				default: host_out_q <= host_out_q;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	logic [4:0] tx_cnt_q;
	logic [4:0] cdr_cnt_q;
	logic [7:0] cc_cnt_q;
	logic tx20_q;
	logic cdr20_q;
	logic cclk_q;
	logic [7:0] srcs;
	logic [1:0] sel [0:2];

	always_ff @(posedge i_sys_clk) begin
		if (rst_all) begin
			por_q <= 1'b1;
		end else begin
			por_q <= 1'b0;
		end
	end

	// Output dividers toggle every tenth tick, giving one twentieth of the tick rate.
	always_ff @(posedge i_sys_clk) begin
		if (rst_all) begin
			tx_cnt_q <= 5'h00;
			cdr_cnt_q <= 5'h00;
			tx20_q <= 1'b0;
			cdr20_q <= 1'b0;
		end else begin
			if (i_txclk_tick) begin
				tx_cnt_q <= div_step(tx_cnt_q);
				tx20_q <= tx20_q ^ (tx_cnt_q == SGC_DIV20_LAST); // [RULE15]
			end
			if (i_cdrclk_tick) begin
				cdr_cnt_q <= div_step(cdr_cnt_q);
				cdr20_q <= cdr20_q ^ (cdr_cnt_q == SGC_DIV20_LAST); // [RULE15]
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (rst_all) begin
			cc_cnt_q <= 8'h00;
			cclk_q <= 1'b0;
		end else if (cc_cnt_q == SGC_CCLK_LAST) begin
			cc_cnt_q <= 8'h00;
			cclk_q <= ~cclk_q;
		end else begin
			cc_cnt_q <= cc_cnt_q + 8'h01;
		end
	end

	// Index by pin: STAT at n, ALT1 at n+2, ALT2 at n+4.
	// Status bits come through the synchroniser, so the vector follows each status input change four clock edges later.
	assign srcs = {1'b0, cdr20_q, por_q, tx20_q, stat_f[2], cclk_q, stat_f[1], stat_f[0]};

	always_comb begin
		for (int p = 0; p < 3; p++) begin
			sel[p] = pin_sel(2'(p), ctrl_q[p][7:4], host_out_q[p], srcs);
		end
	end

	sgc_gpio_pin u_pin0 (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(rst_all),
		.i_ctrl(sgc_pin_ctrl_s'(ctrl_q[0])),
		.i_src_ok(sel[0][1]),
		.i_src_lvl(sel[0][0]),
		.i_pin_lvl(stat_f[3]),
		.o_pad(o_pad0),
		.o_in_lvl(in_lvl[0])
	);

	sgc_gpio_pin u_pin1 (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(rst_all),
		.i_ctrl(sgc_pin_ctrl_s'(ctrl_q[1])),
		.i_src_ok(sel[1][1]),
		.i_src_lvl(sel[1][0]),
		.i_pin_lvl(stat_f[4]),
		.o_pad(o_pad1),
		.o_in_lvl(in_lvl[1])
	);

	sgc_gpio_pin u_pin2 (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(rst_all),
		.i_ctrl(sgc_pin_ctrl_s'(ctrl_q[2])),
		.i_src_ok(sel[2][1]),
		.i_src_lvl(sel[2][0]),
		.i_pin_lvl(stat_f[5]),
		.o_pad(o_pad2),
		.o_in_lvl(in_lvl[2])
	);

	////////////////////////////////////////////////////////////////////////////
	property p_cs_release;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		!cs_f |=> ##1 !o_sda_oe;
	endproperty
	a_cs_release: assert property (p_cs_release) else $error("data held with select low"); // [RULE2]

	property p_sda_stable;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		($past(scl_f) && scl_f && $past(cs_f) && !$past(start) && !$past(stop)
			&& !$past(rst_all)) |=> $stable(o_sda_oe);
	endproperty
	a_sda_stable: assert property (p_sda_stable) else $error("data moved with clock high"); // [RULE3]

	property p_start_rx;
		@(posedge i_sys_clk) disable iff (rst_all)
		start |=> (st_q == SGC_ST_RX) && (bit_q == 3'd0) && (kind_q == SGC_KIND_ADDR);
	endproperty
	a_start_rx: assert property (p_start_rx) else $error("start not taken"); // [RULE4]

	property p_idx_ack;
		@(posedge i_sys_clk) disable iff (rst_all)
		(byte_done && kind_q == SGC_KIND_IDX && !start && !stop && cs_f)
			|=> st_q == SGC_ST_RXACK && ack_q && idx_q == $past(rx_byte);
	endproperty
	a_idx_ack: assert property (p_idx_ack) else $error("index byte not acked"); // [RULE5]

	property p_addr_ack;
		@(posedge i_sys_clk) disable iff (rst_all)
		(byte_done && kind_q == SGC_KIND_ADDR) |=> ack_q == ($past(rx_byte[7:1]) == dev_addr_q);
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address match wrong"); // [RULE1]

	property p_autoinc;
		@(posedge i_sys_clk) disable iff (rst_all)
		wr_en |=> idx_q == $past(idx_q) + 8'h01;
	endproperty
	a_autoinc: assert property (p_autoinc) else $error("index not incremented"); // [RULE8]

	property p_nack_stop;
		@(posedge i_sys_clk) disable iff (rst_all)
		(st_q == SGC_ST_TXACK && scl_rise && sda_f && cs_f && !start && !stop)
			|=> st_q == SGC_ST_IDLE ##1 !o_sda_oe;
	endproperty
	a_nack_stop: assert property (p_nack_stop) else $error("read not ended on nack"); // [RULE11]

	property p_soft_rst;
		@(posedge i_sys_clk) disable iff (rst_all)
		(wr_en && idx_q == SGC_REG_SOFT_RST && rx_byte[SGC_SOFT_RST_BIT])
			|=> ctrl_q[0] == SGC_PIN_CTRL_RST && dev_addr_q == $past(dev_addr_q);
	endproperty
	a_soft_rst: assert property (p_soft_rst) else $error("soft reset wrong"); // [RULE21]

	property p_reserved_hiz;
		@(posedge i_sys_clk) disable iff (rst_all)
		(ctrl_q[0][7:4] > SGC_FN_STAT || ctrl_q[0][7:4] == SGC_FN_HOST_IN) |=> !o_pad0.oe;
	endproperty
	a_reserved_hiz: assert property (p_reserved_hiz) else $error("pin driven on bad code"); // [RULE23]

	property p_pin0_status;
		@(posedge i_sys_clk) disable iff (rst_all)
		ctrl_q[0] == 8'h21 |=> o_pad0.oe && !o_pad0.ibe && !o_pad0.pu && !o_pad0.pd
			&& o_pad0.out == $past(stat_f[0]);
	endproperty
	a_pin0_status: assert property (p_pin0_status) else $error("pin 0 status wrong"); // [RULE19]

	c_write: cover property (@(posedge i_sys_clk) disable iff (rst_all) wr_en);
	c_read_nack: cover property (@(posedge i_sys_clk) disable iff (rst_all)
		st_q == SGC_ST_TXACK && scl_rise && sda_f);
	c_read_burst: cover property (@(posedge i_sys_clk) disable iff (rst_all)
		st_q == SGC_ST_TXACK && scl_rise && !sda_f);
endmodule : sgc_smbus_gpio

// ==== logic/sgc_sync.sv ====
// Three-flop synchroniser with a level filter for asynchronous inputs.
// Assumes the inputs are quasi-static compared with the system clock.
`timescale 1ns/1ps
module sgc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RSTV = '0
) (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_level
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			s1_q <= RSTV;
			s2_q <= RSTV;
			s3_q <= RSTV;
		end else begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A bit only moves once the last two stages agree, which drops one-cycle glitches.
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			o_level <= RSTV;
		end else begin
			for (int b = 0; b < W; b++) begin
				if (s2_q[b] == s3_q[b]) begin
					o_level[b] <= s3_q[b];
				end
			end
		end
	end
endmodule : sgc_sync

// ==== verification/sgc_host_model.sv ====
// Behavioural configuration bus host: bit-bangs clock and data as an open-drain master.
// Assumes the bench resolves the data wire and feeds it back on i_sda_line.
`timescale 1ns/1ps
module sgc_host_model #(
	parameter int QTR = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_sda_line,
	output logic o_scl,
	output logic o_sda,
	output logic o_rd_valid,
	output logic [7:0] o_rd_byte
);
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
		o_rd_valid = 1'b0;
		o_rd_byte = 8'h00;
	end

	// A quarter bit is long enough for the target's input synchroniser.
	task automatic qtr();
		repeat (QTR) @(posedge i_sys_clk);
	endtask : qtr

	////////////////////////////////////////////////////////////////////////////
	task automatic bit_x(input logic b, output logic r);
		o_sda <= b;
		qtr();
		o_scl <= 1'b1;
		qtr();
		r = i_sda_line;
		qtr();
		o_scl <= 1'b0;
		qtr();
	endtask : bit_x

	task automatic start_c();
		o_sda <= 1'b1;
		qtr();
		o_scl <= 1'b1;
		qtr();
		o_sda <= 1'b0;
		qtr();
		o_scl <= 1'b0;
		qtr();
	endtask : start_c

	task automatic stop_c();
		o_sda <= 1'b0;
		qtr();
		o_scl <= 1'b1;
		qtr();
		o_sda <= 1'b1;
		qtr();
	endtask : stop_c

	task automatic byte_x(input logic [7:0] d, input logic ab, output logic [7:0] r,
			output logic ok);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r[i]);
		end
		bit_x(ab, a);
		ok = !a;
	endtask : byte_x

	////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [6:0] adr, input logic [7:0] idx, input logic [7:0] d[$],
			output logic ok);
		logic [7:0] r;
		logic k;
		start_c();
		byte_x({adr, 1'b0}, 1'b1, r, ok);
		byte_x(idx, 1'b1, r, k);
		ok &= k;
		foreach (d[i]) begin
			byte_x(d[i], 1'b1, r, k);
			ok &= k;
		end
		stop_c();
	endtask : wr

	task automatic rd(input logic [6:0] adr, input logic [7:0] idx, input int n,
			output logic ok);
		logic [7:0] r;
		logic k;
		start_c();
		byte_x({adr, 1'b0}, 1'b1, r, ok);
		byte_x(idx, 1'b1, r, k);
		ok &= k;
		start_c();
		byte_x({adr, 1'b1}, 1'b1, r, k);
		ok &= k;
		for (int i = 0; i < n; i++) begin
			byte_x(8'hff, i == n - 1, r, k);
			o_rd_byte <= r;
			o_rd_valid <= 1'b1;
			@(posedge i_sys_clk);
			o_rd_valid <= 1'b0;
		end
		stop_c();
	endtask : rd
endmodule : sgc_host_model

// ==== verification/sgc_smbus_gpio_tb.sv ====
// Self-checking bench for the configuration bus target and its three pins.
// Assumes the host model is the only bus master and the data line has a pull-up.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
	$display("Error at time %0t: got %h expected %h", $time, a, e); end end
module sgc_smbus_gpio_tb;
	import sgc_pkg::*;
	logic clk = 0, rst = 1, rst_n = 1, cs = 1, det0 = 0, det1 = 0, lock = 0;
	logic txt = 0, cdt = 0, scl, hsda, line, oe, sout, rv, ok;
	logic [2:0] pins = 3'h0;
	logic [7:0] rb, ev, tick = 8'h00;
	logic [31:0] seed = 32'ha4cb, v;
	logic [6:0] adr = SGC_DEV_ADDR_RST;
	sgc_pad_s p0, p1, p2, pp;
	int failures = 0, n_tests = 0;
	logic [7:0] exp_q[$];
	logic [7:0] f_idx[9] = '{8'h02, 8'h03, 8'h03, 8'h03, 8'h03, 8'h02, 8'h02, 8'h04, 8'h04};
	logic [7:0] f_val[9] = '{8'h21, 8'h21, 8'h31, 8'h41, 8'h11, 8'hf1, 8'h31, 8'h21, 8'h31};
	int f_src[9] = '{0, 1, 2, 5, 3, 3, 3, 4, 4};

	always #2 clk = ~clk;
	assign line = hsda & (~oe | sout);

	sgc_smbus_gpio dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_reset_n(rst_n),
		.i_config_bus_select(cs), .i_scl(scl), .i_sda(line), .o_sda_out(sout), .o_sda_oe(oe),
		.i_sig_det0(det0), .i_sig_det1(det1), .i_cdr_lock(lock), .i_txclk_tick(txt),
		.i_cdrclk_tick(cdt), .i_pin(pins), .o_pad0(p0), .o_pad1(p1), .o_pad2(p2));
	sgc_host_model host (.i_sys_clk(clk), .i_sda_line(line), .o_scl(scl), .o_sda(hsda),
		.o_rd_valid(rv), .o_rd_byte(rb));

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude

	task automatic settle();
		repeat (12) @(posedge clk);
	endtask : settle

	// Measures one half period of the pin 2 output; a stuck pin runs out the bound.
	task automatic half_per(input logic [7:0] val, input int exp_n);
		logic l;
		int n;
		host.wr(adr, SGC_REG_PIN2, '{val}, ok);
		settle();
		l = p2[4];
		n = 0;
		while (p2[4] == l && n < 300) begin
			@(posedge clk);
			n++;
		end
		l = p2[4];
		n = 0;
		while (p2[4] == l && n < 300) begin
			@(posedge clk);
			n++;
		end
		`CHK(n, exp_n)
	endtask : half_per

	////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		tick <= tick + 8'h01;
		txt <= tick[0];
		cdt <= &tick[1:0];
		if (rv) begin
			if (exp_q.size() == 0) begin
				`CHK(exp_q.size(), 1)
			end else begin
				ev = exp_q.pop_front();
				`CHK(rb, ev)
			end
		end
	end

	initial begin
		for (int i = 0; i < 90000; i++) @(posedge clk);
		`CHK(1'b0, 1'b1)
		conclude();
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		repeat (3) exp_q.push_back(SGC_PIN_CTRL_RST);
		host.rd(adr, SGC_REG_PIN0, 3, ok);
		`CHK(ok, 1'b1)
		$display("test defaults done");

		foreach (f_idx[i]) begin
			host.wr(adr, f_idx[i], '{f_val[i]}, ok);
			`CHK(ok, 1'b1)
			repeat (2) begin
				v = rnd();
				det0 <= v[0];
				det1 <= v[1];
				lock <= v[2];
				settle();
				pp = f_idx[i] == SGC_REG_PIN0 ? p0 : (f_idx[i] == SGC_REG_PIN1 ? p1 : p2);
				`CHK(pp[3:0], {f_src[i] != 3, 3'b000})
				if (f_src[i] < 3 || f_src[i] == 5) begin
					`CHK(pp[4], f_src[i] == 5 ? 1'b0 : v[f_src[i]])
				end
			end
		end
		$display("test functions done");

		host.wr(adr, SGC_REG_PIN0, '{8'h0c, 8'h16, 8'h0b}, ok);
		settle();
		`CHK({p0[3:0], p1[3:0], p2[3:0]}, 12'h03d)
		exp_q.push_back(8'h0c);
		exp_q.push_back(8'h16);
		exp_q.push_back(8'h0b);
		host.rd(adr, SGC_REG_PIN0, 3, ok);
		$display("test bias and increment done");

		v = rnd();
		pins <= {v[2], v[5], v[4]};
		host.wr(adr, SGC_REG_PIN_LVL, '{{5'h00, v[2:0]}}, ok);
		settle();
		`CHK(p2[4], v[2])
		exp_q.push_back({1'b0, v[2], v[5], 2'b00, v[2:0]});
		host.rd(adr, SGC_REG_PIN_LVL, 1, ok);
		$display("test levels done");

		// Transmit ticks come every second cycle and recovered ticks every fourth.
		half_per(8'h21, SGC_CCLK_LAST + 1);
		half_per(8'h31, 20);
		half_per(8'h41, 40);
		$display("test clocks done");

		cs <= 1'b0;
		settle();
		host.wr(adr, SGC_REG_PIN0, '{8'h21}, ok);
		`CHK(ok, 1'b0)
		`CHK(sout, 1'b0)
		cs <= 1'b1;
		settle();
		host.wr(7'h2c, SGC_REG_PIN0, '{8'h21}, ok);
		`CHK(ok, 1'b0)
		exp_q.push_back(8'h0c);
		host.rd(adr, SGC_REG_PIN0, 1, ok);
		$display("test refusals done");

		host.wr(adr, SGC_REG_DEV_ADDR, '{8'h33}, ok);
		adr = 7'h33;
		host.wr(adr, SGC_REG_SOFT_RST, '{8'h01}, ok);
		settle();
		exp_q.push_back(8'h33);
		exp_q.push_back(SGC_PIN_CTRL_RST);
		host.rd(adr, SGC_REG_DEV_ADDR, 2, ok);
		`CHK(ok, 1'b1)
		$display("test soft reset done");

		rst_n <= 1'b0;
		settle();
		rst_n <= 1'b1;
		settle();
		adr = SGC_DEV_ADDR_RST;
		exp_q.push_back({1'b0, SGC_DEV_ADDR_RST});
		exp_q.push_back(SGC_PIN_CTRL_RST);
		host.rd(adr, SGC_REG_DEV_ADDR, 2, ok);
		`CHK(ok, 1'b1)
		`CHK(exp_q.size(), 0)
		$display("test reset pin done");
		conclude();
	end
endmodule : sgc_smbus_gpio_tb
